/* File: bench/cget_cmd_src.sv */
`timescale 1ns/10ps
// ==================================================
// acquisition-side source of run, halt and event pulses
module cget_cmd_src
(
  // clock
  input  wire logic core_clk,
  // active-low command pins, idle high
  output logic      run_n,
  output logic      halt_n,
  output logic      event_n
);
  logic [2:0] pins_n = 3'h7;
  logic       halted = 1'b1;

  // pin order: 0 run, 1 halt, 2 event
  assign {event_n, halt_n, run_n} = pins_n;

  // 12 cycles low is 60 ns, so short pulses never reach the device
  task automatic pulse(input int which);
    if (which == 0 && !halted) return;
    halted = (which == 1) ? 1'b1 : ((which == 0) ? 1'b0 : halted);
    @(posedge core_clk);
    pins_n[which] <= 1'b0;
    repeat (12) @(posedge core_clk);
    pins_n[which] <= 1'b1;
  endtask
endmodule

/* File: bench/cget_timer_props.sv */
`timescale 1ns/10ps
module cget_timer_props
  import cget_pkg::*;
(
  // clock and reset
  input  wire logic                   core_clk,
  input  wire logic                   reset_n,
  // command pulses and straps
  input  wire logic                   run_n,
  input  wire logic                   halt_n,
  input  wire logic                   event_n,
  input  wire logic                   freq_select_strap_low,
  input  wire logic                   freq_select_strap_high,
  // command port
  input  wire logic                   cmd_valid,
  input  wire logic [4:0]             cmd_func,
  input  wire logic [3:0]             cmd_addr,
  input  wire logic [DATA_W-1:0]      cmd_rdata,
  input  wire logic                   cmd_q,
  input  wire logic                   cmd_x,
  // outputs
  input  wire logic                   attention_request,
  input  wire logic [NUM_OUT_CLK-1:0] ext_clk
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  // ==================================================
  // ages since event, unmask and halt; saturate so they never wrap
  logic       evt_pin_ff;
  logic [7:0] evt_age_ff;
  logic [7:0] unm_age_ff;
  logic [7:0] halt_age_ff;
  function automatic logic [7:0] sat(input logic [7:0] a);
    return (a == 8'hFF) ? a : a + 8'h01;
  endfunction
  wire        take_unm     = cmd_valid && cmd_func == FN_ENABLE;
  wire  [7:0] nxt_evt_age  = (evt_pin_ff && !event_n) ? 8'h00 : sat(evt_age_ff);
  wire  [7:0] nxt_unm_age  = take_unm ? 8'h00 : sat(unm_age_ff);
  wire  [7:0] nxt_halt_age = !run_n ? 8'h00 :
                             (halt_age_ff == 8'h00) ? {7'h00, !halt_n} : sat(halt_age_ff);
  always_ff @(posedge core_clk)
  begin
    evt_pin_ff  <= event_n;
    evt_age_ff  <= reset_n ? nxt_evt_age : 8'hFF;
    unm_age_ff  <= reset_n ? nxt_unm_age : 8'hFF;
    halt_age_ff <= reset_n ? nxt_halt_age : 8'h00;
  end

  // ==================================================
  // output clocks
  a_ext_same: assert property (ext_clk == {NUM_OUT_CLK{ext_clk[0]}})
    else $error("output clocks differ");
  a_off_still: assert property ((freq_select_strap_low && freq_select_strap_high) [*6]
    |-> $stable(ext_clk))
    else $error("clock moves with both straps absent");
  a_halt_stops: assert property (halt_age_ff >= 8'h46 |-> ext_clk == 8'h00)
    else $error("clock still running after halt");

  // ==================================================
  // attention and registers
  a_attn_delay: assert property ($rose(attention_request) && unm_age_ff > 8'h08
    |-> evt_age_ff >= 8'hC8 && evt_age_ff <= 8'hDC)
    else $error("attention not about 1 us after event");
  a_mask_blocks: assert property (cmd_valid && cmd_func == FN_DISABLE && cmd_addr == 4'h0
    |-> ##2 !attention_request)
    else $error("attention passes a closed mask");
  a_reg1_bit11: assert property (cmd_valid && cmd_func == FN_READ && cmd_addr == SA_REG1
    |=> !cmd_rdata[11])
    else $error("register one bit 11 set");
  a_reg3_upper: assert property (cmd_valid && cmd_func == FN_READ && cmd_addr == SA_REG3
    |=> cmd_rdata[15:5] == 11'h000)
    else $error("register three upper bits set");
  a_strap_view: assert property (cmd_valid && cmd_func == FN_READ && cmd_addr == SA_REG3
    && $past(reset_n) && $stable({freq_select_strap_high, freq_select_strap_low})
    |=> cmd_rdata[3:2] == $past({freq_select_strap_high, freq_select_strap_low}))
    else $error("strap bits wrong in register three");

  c_attn: cover property ($rose(attention_request));
  c_halt: cover property (halt_age_ff == 8'h46);
  c_unmask: cover property (take_unm);
endmodule

bind cget_clock_gate_event_timer cget_timer_props u_props
(
  .core_clk(core_clk), .reset_n(reset_n), .run_n(run_n), .halt_n(halt_n),
  .event_n(event_n), .freq_select_strap_low(freq_select_strap_low),
  .freq_select_strap_high(freq_select_strap_high), .cmd_valid(cmd_valid),
  .cmd_func(cmd_func), .cmd_addr(cmd_addr), .cmd_rdata(cmd_rdata), .cmd_q(cmd_q),
  .cmd_x(cmd_x), .attention_request(attention_request), .ext_clk(ext_clk)
);

/* File: bench/tb_cget_clock_gate_event_timer.sv */
`timescale 1ns/10ps
module tb_cget_clock_gate_event_timer;
  import cget_pkg::*;

  // ==================================================
  // pins, bookkeeping and model state
  logic                   core_clk = 1'b0;
  logic                   reset_n = 1'b0;
  logic                   strap_lo = 1'b0;
  logic                   strap_hi = 1'b0;
  logic                   cmd_valid = 1'b0;
  logic [4:0]             cmd_func = 5'h00;
  logic [3:0]             cmd_addr = 4'h0;
  logic [DATA_W-1:0]      cmd_rdata;
  logic                   cmd_q;
  logic                   cmd_x;
  logic                   attention_request;
  logic [NUM_OUT_CLK-1:0] ext_clk;
  wire                    run_n;
  wire                    halt_n;
  wire                    event_n;
  int                     num_errors = 0;
  int                     n_tests = 0;
  int                     cyc = 0;
  int                     m_attn = 0;
  int                     m_mask = 0;
  int                     m_first = 0;
  int                     ev_q[$];
  logic [DATA_W-1:0]      rd;
  logic                   rq;
  logic                   rx;

  cget_clock_gate_event_timer dut
  (
    .core_clk(core_clk), .reset_n(reset_n), .run_n(run_n), .halt_n(halt_n),
    .event_n(event_n), .freq_select_strap_low(strap_lo), .freq_select_strap_high(strap_hi),
    .cmd_valid(cmd_valid), .cmd_func(cmd_func), .cmd_addr(cmd_addr),
    .cmd_rdata(cmd_rdata), .cmd_q(cmd_q), .cmd_x(cmd_x),
    .attention_request(attention_request), .ext_clk(ext_clk)
  );
  cget_cmd_src u_src
  (
    .core_clk(core_clk), .run_n(run_n), .halt_n(halt_n), .event_n(event_n)
  );

  always #2.5 core_clk = ~core_clk;
  // hang guard, the run needs well under this many cycles
  always @(posedge core_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 60000)
    begin
      num_errors++;
      tally_and_finish();
    end
  end

  // ==================================================
  // helpers
  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // counts may be one off; unsigned wrap is exact as every modulus is a power of two
  function automatic logic near(input logic [31:0] a, input logic [31:0] b, input logic [31:0] m);
    logic [31:0] d;
    d = (a - b) % m;
    return d <= 1 || d == m - 1;
  endfunction

  function automatic logic [15:0] r3();
    return {11'h000, m_first[0], strap_hi, strap_lo, m_mask[0], m_attn[0]};
  endfunction

  // one command, answer sampled in the cycle after it is taken
  task automatic cmd(input logic [4:0] f, input logic [3:0] a);
    @(posedge core_clk);
    cmd_valid <= 1'b1;
    cmd_func  <= f;
    cmd_addr  <= a;
    @(posedge core_clk);
    cmd_valid <= 1'b0;
    #1;
    rd = cmd_rdata;
    rq = cmd_q;
    rx = cmd_x;
    if (f == FN_CLEAR || (f == FN_READ && (a == SA_REG1 || a == SA_REG2))) m_attn = 0;
    if (f == FN_DISABLE || f == FN_ENABLE) m_mask = (f == FN_ENABLE);
    if (f == FN_RESET) {m_first[0], m_mask[0], m_attn[0]} = 3'h0;
  endtask

  task automatic wait_rise(output int t);
    int   k;
    logic p;
    #1;
    p = ext_clk[0];
    t = -1;
    for (k = 0; k < 200 && t < 0; k++)
    begin
      @(posedge core_clk);
      #1;
      if (ext_clk[0] && !p) t = cyc;
      p = ext_clk[0];
    end
  endtask

  task automatic restart(output int t);
    u_src.pulse(1);
    repeat (60) @(posedge core_clk);
    u_src.pulse(0);
    wait_rise(t);
  endtask

  task automatic event_now();
    ev_q.push_back(cyc);
    u_src.pulse(2);
    repeat (215) @(posedge core_clk);
    #1;
    m_attn = 1;
    m_first = 1;
  endtask

  // ==================================================
  // main sequence
  initial
  begin
    int code, i, s, e, t0, t1, k;
    s = $urandom(80);
    repeat (4) @(posedge core_clk);
    reset_n <= 1'b1;
    repeat (2) @(posedge core_clk);
    cmd(FN_READ, SA_REG3);
    check(rd, r3());
    cmd(FN_READ, 4'h3);
    check({rd, rq, rx}, 18'h0);
    // every strap code: 8 reference ticks take 50 cycles, and code 3 gives no clock
    for (code = 0; code < 4; code++)
    begin
      @(posedge core_clk);
      {strap_hi, strap_lo} <= code[1:0];
      restart(t0);
      cmd(FN_READ, SA_REG3);
      check(rd, r3());
      check(t0 < 0, code == 3);
      for (k = 0; k < (1 << code) && code < 3; k++) wait_rise(t1);
      if (code < 3) check(24'(t1 - t0), 24'h32);
      u_src.pulse(1);
      repeat (70) @(posedge core_clk);
      wait_rise(t1);
      check(t1 < 0, 1'b1);
    end
    $display("test strap sweep done");
    // position and interval at the slowest clock, masked attention
    @(posedge core_clk);
    {strap_hi, strap_lo} <= 2'h0;
    for (i = 0; i < 5; i++)
    begin
      s = $urandom_range(20, 0);
      restart(t0);
      repeat (50 * s + 20) @(posedge core_clk);
      event_now();
      check(attention_request, 1'b0);
      cmd(FN_READ, SA_REG3);
      check(rd, r3());
      cmd(FN_READ, SA_REG1);
      check(near(rd[15:12], s, 16), 1'b1);
      check(near(rd[10:8], 4, 8), 1'b1);
      e = (ev_q.size() < 2) ? 0 : (ev_q[$] - ev_q[$-1] - 200) / 50;
      t1 = rd[7:0];
      cmd(FN_READ, SA_REG2);
      check(near(t1 * 65536 + rd, e, 1 << 24), 1'b1);
    end
    $display("test position and interval done");
    // attention through the mask, test, clear, read and board reset
    cmd(FN_ENABLE, 4'h0);
    check(rx, 1'b1);
    event_now();
    check(attention_request, 1'b1);
    cmd(FN_TEST, SA_CTRL);
    check(rq, 1'b1);
    cmd(FN_CLEAR, 4'h0);
    repeat (3) @(posedge core_clk);
    #1;
    check(attention_request, 1'b0);
    event_now();
    cmd(FN_DISABLE, 4'h0);
    repeat (3) @(posedge core_clk);
    #1;
    check(attention_request, 1'b0);
    cmd(FN_READ, SA_REG3);
    check(rd, r3());
    cmd(FN_READ, SA_REG2);
    cmd(FN_READ, SA_REG3);
    check(rd, r3());
    cmd(FN_RESET, SA_CTRL);
    repeat (4) @(posedge core_clk);
    cmd(FN_READ, SA_REG3);
    check(rd, r3());
    $display("test attention done");
    tally_and_finish();
  end

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0)
    begin
      $display("TEST PASSED");
    end
    else
    begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
endmodule

/* File: src/cget_clock_gate_event_timer.sv */
`timescale 1ns/10ps
module cget_clock_gate_event_timer
  import cget_pkg::*;
(
  // clock and reset
  input  wire logic                   core_clk,
  input  wire logic                   reset_n,
  // command pulses, active low, asynchronous
  input  wire logic                   run_n,
  input  wire logic                   halt_n,
  input  wire logic                   event_n,
  // frequency select straps, fitted strap reads 0
  input  wire logic                   freq_select_strap_low,
  input  wire logic                   freq_select_strap_high,
  // command port
  input  wire logic                   cmd_valid,
  input  wire logic [4:0]             cmd_func,
  input  wire logic [3:0]             cmd_addr,
  output logic [DATA_W-1:0]           cmd_rdata,
  output logic                        cmd_q,
  output logic                        cmd_x,
  // attention request, after the mask
  output logic                        attention_request,
  // gated external clocks
  output logic [NUM_OUT_CLK-1:0]      ext_clk
);

  // ==========================================================================
  // declarations
  logic                 run_pulse, halt_pulse, event_pulse;
  logic                 soft_rst_ff, rst_all;
  logic [1:0]           strap_ff;
  logic [4:0]           ref_acc_ff;
  logic [5:0]           ref_acc_sum;
  logic                 ref_wrap, ref_tick_ff;
  logic [2:0]           ref_div_ff, div_mask, div_half, phase, phase_next;
  logic                 clk_off, sample_rise, sample_fall, sample_level;
  logic                 run_pend_ff, halt_pend_ff, gate_on_ff, nxt_gate_on;
  logic [NUM_OUT_CLK-1:0] ext_clk_ff;
  logic [3:0]           window_slot_count_ff, fine_slot_count_ff;
  logic                 pos_arm_ff, pos_en_ff;
  logic [IVL_W-1:0]     ivl_cnt_ff, ivl_latch_ff;
  logic                 first_event_ff, ivl_en_ff;
  cget_ev_state_e       ev_state_ff;
  logic [7:0]           hold_cnt_ff;
  logic                 hold_done;
  logic [7:0]           pos_latch_ff;
  logic                 attn_ff, mask_en_ff, attention_ff;
  logic                 cmd_read1, cmd_read2, cmd_read3, cmd_test, cmd_reset;
  logic                 cmd_clear, cmd_disable, cmd_enable, cmd_known;
  logic [DATA_W-1:0]    reg1_val, reg2_val, reg3_val;
  logic [DATA_W-1:0]    nxt_rdata, rdata_ff;
  logic                 q_ff, x_ff;

  // ==========================================================================
  // pin synchronisers
  cget_pulse_sync u_run_sync
  (
    .core_clk   (core_clk),
    .reset_n    (reset_n),
    .pulse_n    (run_n),
    .fall_pulse (run_pulse)
  );

  cget_pulse_sync u_halt_sync
  (
    .core_clk   (core_clk),
    .reset_n    (reset_n),
    .pulse_n    (halt_n),
    .fall_pulse (halt_pulse)
  );

  cget_pulse_sync u_event_sync
  (
    .core_clk   (core_clk),
    .reset_n    (reset_n),
    .pulse_n    (event_n),
    .fall_pulse (event_pulse)
  );

  // ==========================================================================
  // reset: pin reset or the board reset command
  assign rst_all = ~reset_n | soft_rst_ff;

  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
      soft_rst_ff <= 1'b0;
    else
      soft_rst_ff <= cmd_reset;
  end

  // straps are sampled every cycle so a refit takes effect live
  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
      strap_ff <= SEL_OFF;
    else
      strap_ff <= {freq_select_strap_high, freq_select_strap_low};
  end

  // ==========================================================================
  // 32 MHz reference tick from the 200 MHz core clock
  // fractional divider: ticks jitter by one core cycle, average rate exact
  assign ref_acc_sum = {1'b0, ref_acc_ff} + {1'b0, REF_STEP};
  assign ref_wrap    = (ref_acc_sum >= {1'b0, REF_MOD});

  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
    begin
      ref_acc_ff  <= 5'h00;
      ref_tick_ff <= 1'b0;
    end
    else
    begin
      ref_acc_ff  <= ref_wrap ? 5'(ref_acc_sum - {1'b0, REF_MOD}) : ref_acc_sum[4:0];
      ref_tick_ff <= ref_wrap;
    end
  end

  // ==========================================================================
  // sample clock: reference divided by 8, 4 or 2 per straps
  assign div_mask = (strap_ff == SEL_4MHZ)  ? MASK_DIV8 :
                    (strap_ff == SEL_8MHZ)  ? MASK_DIV4 :
                                              MASK_DIV2;
  assign div_half = (strap_ff == SEL_4MHZ)  ? HALF_DIV8 :
                    (strap_ff == SEL_8MHZ)  ? HALF_DIV4 :
                                              HALF_DIV2;
  assign clk_off      = (strap_ff == SEL_OFF);
  assign phase        = ref_div_ff & div_mask;
  assign phase_next   = 3'(phase + 3'h1) & div_mask;
  // rising edge coincides with a reference tick where the phase wraps
  assign sample_rise  = ref_tick_ff & ~clk_off & (phase == div_mask);
  assign sample_fall  = ref_tick_ff & ~clk_off & (phase_next == div_half);
  // level high in the first half of the period, so it rises on the wrap
  assign sample_level = ~clk_off & ((phase & div_half) == 3'h0);

  // divider keeps running through halt; only outputs are gated
  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
      ref_div_ff <= 3'h0;
    else if (ref_tick_ff)
      ref_div_ff <= 3'(ref_div_ff + 3'h1);
  end

  // ==========================================================================
  // output gate: run opens on a rise, halt closes on the next fall
  // far side halts before a new run; a halt also drops a start still pending
  assign nxt_gate_on = (run_pend_ff & sample_rise)  ? 1'b1 :
                       (halt_pend_ff & sample_fall) ? 1'b0 :
                                                      gate_on_ff;

  always_ff @(posedge core_clk)
  begin
    if (rst_all)
    begin
      run_pend_ff  <= 1'b0;
      halt_pend_ff <= 1'b0;
      gate_on_ff   <= 1'b0;
    end
    else
    begin
      run_pend_ff  <= run_pulse | (run_pend_ff & ~sample_rise & ~halt_pulse);
      halt_pend_ff <= halt_pulse | (halt_pend_ff & ~sample_fall);
      gate_on_ff   <= nxt_gate_on;
    end
  end

  // eight identical copies; registered so each pin is a flop output
  genvar gi;
  generate
    for (gi = 0; gi < NUM_OUT_CLK; gi++)
    begin : g_ext
      always_ff @(posedge core_clk)
      begin
        if (rst_all)
          ext_clk_ff[gi] <= 1'b0;
        else
          ext_clk_ff[gi] <= sample_level & nxt_gate_on;
      end
    end
  endgenerate

  // ==========================================================================
  // window position counters
  // slot count wraps at sixteen sample periods, which is the window length
  always_ff @(posedge core_clk)
  begin
    if (rst_all)
    begin
      window_slot_count_ff <= 4'h0;
      fine_slot_count_ff   <= 4'h0;
      pos_arm_ff           <= 1'b0;
      pos_en_ff            <= 1'b0;
    end
    else if (run_pulse)
    begin
      window_slot_count_ff <= 4'h0;
      fine_slot_count_ff   <= 4'h0;
      pos_arm_ff           <= 1'b1;
      pos_en_ff            <= 1'b0;
    end
    else if (event_pulse)
      pos_en_ff <= 1'b0;
    else if (pos_arm_ff)
    begin
      // enable on the first sample rise after the clear
      if (sample_rise)
      begin
        pos_arm_ff <= 1'b0;
        pos_en_ff  <= 1'b1;
      end
    end
    else if (pos_en_ff)
    begin
      if (sample_rise)
      begin
        window_slot_count_ff <= 4'(window_slot_count_ff + 4'h1);
        fine_slot_count_ff   <= 4'h0;
      end
      else if (ref_tick_ff)
        fine_slot_count_ff <= 4'(fine_slot_count_ff + 4'h1);
    end
  end

  // ==========================================================================
  // event sequencer: 1 us hold after each event seen while idle
  assign hold_done = (ev_state_ff == EV_HOLD) & (hold_cnt_ff == EVT_HOLD_LAST);

  always_ff @(posedge core_clk)
  begin
    if (rst_all)
    begin
      ev_state_ff <= EV_IDLE;
      hold_cnt_ff <= 8'h00;
    end
    else
    begin
      unique case (ev_state_ff)
        EV_IDLE:
        begin
          hold_cnt_ff <= 8'h00;
          if (event_pulse)
            ev_state_ff <= EV_HOLD;
        end
        EV_HOLD:
        begin
          // an event inside the hold is absorbed by the running hold
          hold_cnt_ff <= 8'(hold_cnt_ff + 8'h01);
          if (hold_done)
            ev_state_ff <= EV_IDLE;
        end
      endcase
    end
  end

  // ==========================================================================
  // interval counter and latches
  always_ff @(posedge core_clk)
  begin
    if (rst_all)
    begin
      ivl_cnt_ff     <= '0;
      ivl_latch_ff   <= '0;
      ivl_en_ff      <= 1'b0;
      first_event_ff <= 1'b0;
      pos_latch_ff   <= 8'h00;
    end
    else
    begin
      if (event_pulse & (ev_state_ff == EV_IDLE))
      begin
        ivl_en_ff      <= 1'b0;
        ivl_latch_ff   <= ivl_cnt_ff;
        first_event_ff <= 1'b1;
      end
      else if (hold_done)
      begin
        ivl_cnt_ff   <= '0;
        ivl_en_ff    <= 1'b1;
        pos_latch_ff <= {window_slot_count_ff, 1'b0, fine_slot_count_ff[2:0]};
      end
      else if (ivl_en_ff & sample_rise)
        ivl_cnt_ff <= IVL_W'(ivl_cnt_ff + 1'b1);
    end
  end

  // ==========================================================================
  // attention flag and mask; a new result wins over a same-cycle clear
  always_ff @(posedge core_clk)
  begin
    if (rst_all)
    begin
      attn_ff      <= 1'b0;
      mask_en_ff   <= 1'b0;
      attention_ff <= 1'b0;
    end
    else
    begin
      attn_ff      <= hold_done | (attn_ff & ~(cmd_read1 | cmd_read2 | cmd_clear));
      mask_en_ff   <= cmd_enable | (mask_en_ff & ~cmd_disable);
      attention_ff <= attn_ff & mask_en_ff;
    end
  end

  // ==========================================================================
  // command decode
  assign cmd_read1   = cmd_valid & (cmd_func == FN_READ)    & (cmd_addr == SA_REG1);
  assign cmd_read2   = cmd_valid & (cmd_func == FN_READ)    & (cmd_addr == SA_REG2);
  assign cmd_read3   = cmd_valid & (cmd_func == FN_READ)    & (cmd_addr == SA_REG3);
  assign cmd_test    = cmd_valid & (cmd_func == FN_TEST)    & (cmd_addr == SA_CTRL);
  assign cmd_reset   = cmd_valid & (cmd_func == FN_RESET)   & (cmd_addr == SA_CTRL);
  assign cmd_clear   = cmd_valid & (cmd_func == FN_CLEAR)   & (cmd_addr == SA_REG1);
  assign cmd_disable = cmd_valid & (cmd_func == FN_DISABLE) & (cmd_addr == SA_REG1);
  assign cmd_enable  = cmd_valid & (cmd_func == FN_ENABLE)  & (cmd_addr == SA_REG1);
  assign cmd_known   = cmd_read1 | cmd_read2 | cmd_read3 | cmd_test |
                       cmd_reset | cmd_clear | cmd_disable | cmd_enable;

  // register images
  assign reg1_val = {pos_latch_ff, ivl_latch_ff[23:16]};
  assign reg2_val = ivl_latch_ff[15:0];
  assign reg3_val = {11'h000, first_event_ff, strap_ff[1], strap_ff[0],
                     mask_en_ff, attn_ff};
  assign nxt_rdata = cmd_read1 ? reg1_val :
                     cmd_read2 ? reg2_val :
                     cmd_read3 ? reg3_val :
                                 16'h0000;

  // answer one cycle after the command; q mirrors masked attention on test
  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
    begin
      rdata_ff <= 16'h0000;
      q_ff     <= 1'b0;
      x_ff     <= 1'b0;
    end
    else
    begin
      rdata_ff <= nxt_rdata;
      q_ff     <= cmd_test ? (attn_ff & mask_en_ff) : cmd_known;
      x_ff     <= cmd_known;
    end
  end

  // ==========================================================================
  // outputs
  assign cmd_rdata         = rdata_ff;
  assign cmd_q             = q_ff;
  assign cmd_x             = x_ff;
  assign attention_request = attention_ff;
  assign ext_clk           = ext_clk_ff;

endmodule

/* File: src/cget_pkg.sv */
// How it works
// - reference ticks divided by 8, 4 or 2 give the 4, 8, 16 MHz sample clock
// - straps high,low: 00 gives 4, 01 gives 8, 10 gives 16, 11 gives none
// - a fitted strap reads as 0, an absent strap as 1
// - both strap levels are readable in the third status register
// - eight clock outputs carry one identical gated sample clock waveform
// - run starts outputs on a sample rising edge, halt stops on next falling
// - reference fixed at 32 MHz; sample and output rising edges align with it
// - halt gates only the outputs; internal clock ticks keep running
// - sample window is sixteen sample periods: 4, 2 or 1 us
// - two 4-bit counters count sample and reference periods; the first wraps each window, the second clears each sample period
// - an event freezes the position counters, outputs keep running
// - position counts latch into upper byte of register one 1 us after event
// - attention flags position ready; result may be lost at next event
// - run clears position counters, counting starts at the next sample rising edge
// - 24-bit interval counter runs on sample clock ticks and wraps
// - interval counter idle after reset until first event, flag readable
// - event stalls interval counter 1 us, latches 24 bits, clears, restarts
// - attention flags interval ready; unread result overwritten by next event
// - attention rises 1 us after event, held until read, clear or reset
// - attention leaves through a mask: reset or disable masks, enable unmasks
// - register three: attention, mask, low strap, high strap, first event
// - bit 11 of register one always reads zero
package cget_pkg;

  // ==========================================================================
  // clocking
  localparam int unsigned CORE_CLK_KHZ  = 200000;
  localparam int unsigned REF_CLK_KHZ   = 32000;
  localparam int unsigned CLK_GCD_KHZ   = 8000;
  localparam int unsigned CORE_PERIOD_NS = 5;
  // fractional divider: REF_STEP ticks per REF_MOD core cycles
  localparam logic [4:0]  REF_STEP      = 5'(REF_CLK_KHZ / CLK_GCD_KHZ);
  localparam logic [4:0]  REF_MOD       = 5'(CORE_CLK_KHZ / CLK_GCD_KHZ);

  // ==========================================================================
  // timing
  localparam int unsigned EVT_HOLD_NS   = 1000;
  localparam int unsigned EVT_HOLD_CYC  = EVT_HOLD_NS / CORE_PERIOD_NS;
  localparam logic [7:0]  EVT_HOLD_LAST = 8'(EVT_HOLD_CYC - 1);

  // ==========================================================================
  // sample clock divider phase masks (divide by 8, 4, 2)
  localparam logic [1:0]  SEL_4MHZ      = 2'h0;
  localparam logic [1:0]  SEL_8MHZ      = 2'h1;
  localparam logic [1:0]  SEL_16MHZ     = 2'h2;
  localparam logic [1:0]  SEL_OFF       = 2'h3;
  localparam logic [2:0]  MASK_DIV8     = 3'h7;
  localparam logic [2:0]  MASK_DIV4     = 3'h3;
  localparam logic [2:0]  MASK_DIV2     = 3'h1;
  localparam logic [2:0]  HALF_DIV8     = 3'h4;
  localparam logic [2:0]  HALF_DIV4     = 3'h2;
  localparam logic [2:0]  HALF_DIV2     = 3'h1;

  // ==========================================================================
  // widths
  localparam int unsigned NUM_OUT_CLK   = 8;
  localparam int unsigned IVL_W         = 24;
  localparam int unsigned DATA_W        = 16;

  // ==========================================================================
  // command decode: function codes and subaddresses
  localparam logic [4:0]  FN_READ       = 5'h00;
  localparam logic [4:0]  FN_TEST       = 5'h08;
  localparam logic [4:0]  FN_RESET      = 5'h09;
  localparam logic [4:0]  FN_CLEAR      = 5'h0A;
  localparam logic [4:0]  FN_DISABLE    = 5'h18;
  localparam logic [4:0]  FN_ENABLE     = 5'h1A;
  localparam logic [3:0]  SA_REG1       = 4'h0;
  localparam logic [3:0]  SA_REG2       = 4'h1;
  localparam logic [3:0]  SA_REG3       = 4'h2;
  localparam logic [3:0]  SA_CTRL       = 4'hF;

  // register three bit positions
  localparam int unsigned R3_ATTN       = 0;
  localparam int unsigned R3_MASK       = 1;
  localparam int unsigned R3_STRAP_LO   = 2;
  localparam int unsigned R3_STRAP_HI   = 3;
  localparam int unsigned R3_FIRST      = 4;

  // event sequencer
  typedef enum logic [0:0]
  {
    EV_IDLE = 1'b0,
    EV_HOLD = 1'b1
  } cget_ev_state_e;

endpackage

/* File: src/cget_pulse_sync.sv */
`timescale 1ns/10ps
// two-flop synchroniser with falling edge detector for active-low pulses
module cget_pulse_sync
(
  // clock and reset
  input  wire logic core_clk,
  input  wire logic reset_n,
  // pin and pulse
  input  wire logic pulse_n,
  output logic      fall_pulse
);

  logic meta_ff;
  logic sync_ff;
  logic prev_ff;

  // ==========================================================================
  // synchroniser: meta_ff is read by sync_ff only
  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
    begin
      meta_ff <= 1'b1;
      sync_ff <= 1'b1;
      prev_ff <= 1'b1;
    end
    else
    begin
      meta_ff <= pulse_n;
      sync_ff <= meta_ff;
      prev_ff <= sync_ff;
    end
  end

  // one-cycle pulse on the leading (falling) edge
  assign fall_pulse = prev_ff & ~sync_ff;

endmodule
